// file: fpu_pkg.sv
package fpu_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  localparam logic [7:0]  OFF_FSCR     = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0]  OFF_IRQ_CLR  = 8'h08;
  localparam logic [7:0]  OFF_IRQ_EN   = 8'h0C;
  localparam logic [7:0]  OFF_FPR_BASE = 8'h80;

  localparam int ROUND_LSB = 0;
  localparam int FLAG_LSB  = 2;
  localparam int EN_LSB    = 7;
  localparam int CAUSE_LSB = 12;
  localparam int DAZ_BIT   = 18;
  localparam int PREC_BIT  = 19;
  localparam int PAIR_BIT  = 20;
  localparam int BANK_BIT  = 21;
  // exception bit order inside flag, enable and cause: I U O Z V, with E in cause only
  localparam int EX_I = 0;
  localparam int EX_U = 1;
  localparam int EX_O = 2;
  localparam int EX_V = 4;
  localparam int EX_E = 5;
  localparam logic [31:0] FSCR_RESET = 32'h0000_0000;
  localparam logic [31:0] FSCR_MASK  = 32'h003F_FFFF;

  localparam logic [4:0] LAT_SGL_MUL  = 5'h01;
  localparam logic [4:0] LAT_DBL_MUL  = 5'h06;
  localparam logic [4:0] LAT_ONE      = 5'h01;
  localparam logic [4:0] LAT_SGL_SQRT = 5'h09;
  localparam logic [4:0] LAT_DBL_SQRT = 5'h16;
  localparam logic [3:0] SQ_ITER_S    = 4'h7;
  localparam logic [3:0] SQ_ITER_D    = 4'hE;

  localparam logic [15:0] OPC_BANK_SWAP = 16'hFBFD;
  localparam logic [15:0] OPC_SIZE_SWAP = 16'hF3FD;
  localparam logic [7:0]  OPC_NEG_LO    = 8'h4D;
  localparam logic [7:0]  OPC_SQRT_LO   = 8'h6D;
  localparam logic [3:0]  OPC_MUL_LO    = 4'h2;
  localparam logic [3:0]  OPC_PREFIX    = 4'hF;

  localparam logic [31:0] QNAN_S = 32'h7FC0_0000;
  localparam logic [63:0] QNAN_D = 64'h7FF8_0000_0000_0000;
  localparam logic signed [12:0] BIAS_S = 13'sh007F;
  localparam logic signed [12:0] BIAS_D = 13'sh03FF;
  localparam logic signed [12:0] EMAX_S = 13'sh00FF;
  localparam logic signed [12:0] EMAX_D = 13'sh07FF;

  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_UNDEF = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [2:0] {CL_NORM, CL_ZERO, CL_INF, CL_DENORM, CL_QNAN, CL_SNAN} fclass_t;
  typedef struct packed {
    fclass_t              cls;
    logic                 sign;
    logic signed [12:0]   exp;
    logic [52:0]          mant;
  } fp_t;
  typedef enum logic [2:0] {OP_NONE, OP_MUL, OP_NEG, OP_SQRT, OP_BANK, OP_SIZE} op_t;
  typedef enum logic {ST_IDLE, ST_RUN} state_t;
endpackage : fpu_pkg

// file: fpu_exec.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - single multiply of regs n and m into n, one state
// - double multiply of pairs n and m into pair n, six states
// - multiply traps whenever overflow, underflow or inexact enable is set
// - on a taken exception cause and flags are updated, destination kept
// - signalling NaN multiply operand gives invalid, highest priority
// - otherwise a quiet NaN operand gives a quiet NaN result
// - otherwise a denormal operand raises FPU error, no product
// - with denormal-as-zero set, denormal operands count as zero
// - negate flips only the sign bit of reg or pair n, one state
// - negate never touches cause or flags and never traps
// - bank swap flips the bank select bit, one state, single mode only
// - bank select picks which physical bank serves as front registers
// - size swap flips transfer size bit 20, undefined in double mode
// - transfer size bit selects single word or word pair moves
// - square root of n in place: 9 states single, 22 double
// - square root traps whenever the inexact enable is set
// - square root special operand classes: error, invalid, pass, quiet NaN
// - round nearest, square back, set inexact, round-to-zero decrements
module fpu_exec (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic              i_issue,
  input  wire logic [15:0]       i_opcode,
  input  wire fpu_pkg::bus_req_t i_bus,
  output logic [31:0]            o_rdata,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_trap,
  output logic                   o_undef,
  output logic                   o_irq,
  output logic                   o_transfer_pair,
  output logic                   o_bank_select
);
  localparam int IRQ_W_T = fpu_pkg::IRQ_W;
  logic [31:0]          fpr [0:31];
  logic [31:0]          float_status_control_reg;
  logic [IRQ_W_T-1:0]   irq_stat;
  logic [IRQ_W_T-1:0]   irq_en;

  logic                 precision_select_bit;
  logic                 transfer_pair_bit;
  logic                 bank_select_bit;
  logic                 denormal_as_zero_bit;
  logic [1:0]           rounding_mode_field;
  logic [4:0]           enable_f;
  assign precision_select_bit = float_status_control_reg[fpu_pkg::PREC_BIT];
  assign transfer_pair_bit    = float_status_control_reg[fpu_pkg::PAIR_BIT];
  assign bank_select_bit      = float_status_control_reg[fpu_pkg::BANK_BIT];
  assign denormal_as_zero_bit = float_status_control_reg[fpu_pkg::DAZ_BIT];
  assign rounding_mode_field  = float_status_control_reg[fpu_pkg::ROUND_LSB +: 2];
  assign enable_f             = float_status_control_reg[fpu_pkg::EN_LSB +: 5];

  fpu_pkg::state_t      state;
  fpu_pkg::op_t         op;
  logic                 dbl;
  logic                 bank;
  logic [3:0]           dst;
  logic [4:0]           cnt;
  logic [3:0]           iter;
  logic [63:0]          pend_val;
  logic                 pend_wr;
  logic [5:0]           pend_cause;
  logic                 pend_force;
  logic                 pend_comp;
  logic                 commit;

  function automatic logic [4:0] pidx(input logic bk, input logic [3:0] r, input logic d, input logic lo);
    return d ? {bk, r[3:1], lo} : {bk, r};
  endfunction : pidx

  function automatic fpu_pkg::fp_t unpack(input logic d, input logic dz, input logic [63:0] v);
    fpu_pkg::fp_t f;
    logic [10:0]  e;
    logic [51:0]  frac;
    logic         top;
    e = d ? v[62:52] : {3'h0, v[30:23]};
    frac = d ? v[51:0] : {v[22:0], 29'h0000_0000};
    top = d ? (e == 11'h7FF) : (e[7:0] == 8'hFF);
    f.sign = d ? v[63] : v[31];
    f.exp = $signed({2'h0, e}) - (d ? fpu_pkg::BIAS_D : fpu_pkg::BIAS_S);
    f.mant = {1'b1, frac};
    if (e == 11'h000)
      f.cls = (frac == 52'h0 || dz) ? fpu_pkg::CL_ZERO : fpu_pkg::CL_DENORM;
    else if (top)
      f.cls = (frac == 52'h0) ? fpu_pkg::CL_INF : (frac[51] ? fpu_pkg::CL_QNAN : fpu_pkg::CL_SNAN);
    else
      f.cls = fpu_pkg::CL_NORM;
    return f;
  endfunction : unpack

  function automatic logic [63:0] pack(input logic d, input logic s, input logic signed [12:0] eb,
                                       input logic [52:0] m);
    return d ? {s, eb[10:0], m[51:0]} : {32'h0000_0000, s, eb[7:0], m[51:29]};
  endfunction : pack

  // round a product or root whose leading one sits at bit 105; a carry shows as bit 53
  function automatic logic [53:0] rnd(input logic d, input logic rz, input logic [105:0] p);
    logic [52:0] sig;
    logic        g;
    logic        st;
    sig = d ? p[105:53] : {p[105:82], 29'h0000_0000};
    g = d ? p[52] : p[81];
    st = d ? |p[51:0] : |p[80:0];
    return {1'b0, sig} + ((!rz && g && (st || (d ? sig[0] : sig[29]))) ? (d ? 54'h1 : 54'h2000_0000) : 54'h0);
  endfunction : rnd

  // issue decode
  logic [3:0]           fld_n;
  logic [3:0]           fld_m;
  logic [63:0]          opn;
  logic [63:0]          opm;
  fpu_pkg::op_t         dec_op;
  fpu_pkg::fp_t         ua;
  fpu_pkg::fp_t         ub;
  logic                 dprec;
  assign dprec = precision_select_bit;
  assign fld_n = i_opcode[11:8];
  assign fld_m = i_opcode[7:4];
  assign opn = dprec ? {fpr[pidx(bank_select_bit, fld_n, 1'b1, 1'b0)], fpr[pidx(bank_select_bit, fld_n, 1'b1, 1'b1)]}
                     : {32'h0000_0000, fpr[pidx(bank_select_bit, fld_n, 1'b0, 1'b0)]};
  assign opm = dprec ? {fpr[pidx(bank_select_bit, fld_m, 1'b1, 1'b0)], fpr[pidx(bank_select_bit, fld_m, 1'b1, 1'b1)]}
                     : {32'h0000_0000, fpr[pidx(bank_select_bit, fld_m, 1'b0, 1'b0)]};
  assign ua = unpack(dprec, denormal_as_zero_bit, opm);
  assign ub = unpack(dprec, denormal_as_zero_bit, opn);

  always_comb
  begin
    dec_op = fpu_pkg::OP_NONE;
    if (i_opcode == fpu_pkg::OPC_BANK_SWAP)
      dec_op = dprec ? fpu_pkg::OP_NONE : fpu_pkg::OP_BANK;
    else if (i_opcode == fpu_pkg::OPC_SIZE_SWAP)
      dec_op = dprec ? fpu_pkg::OP_NONE : fpu_pkg::OP_SIZE;
    else if (i_opcode[15:12] == fpu_pkg::OPC_PREFIX && !(dprec && fld_n[0]))
    begin
      if (i_opcode[7:0] == fpu_pkg::OPC_NEG_LO)
        dec_op = fpu_pkg::OP_NEG;
      else if (i_opcode[7:0] == fpu_pkg::OPC_SQRT_LO)
        dec_op = fpu_pkg::OP_SQRT;
      else if (i_opcode[3:0] == fpu_pkg::OPC_MUL_LO && !(dprec && fld_m[0]))
        dec_op = fpu_pkg::OP_MUL;
    end
  end

  // multiply datapath, evaluated in the issue cycle and held until the last state
  logic [105:0]         prod;
  logic [105:0]         pn;
  logic [53:0]          mr;
  logic signed [12:0]   me;
  logic signed [12:0]   emax;
  logic [63:0]          qnan;
  logic                 sx;
  logic                 rz;
  logic [63:0]          iss_val;
  logic                 iss_wr;
  logic [5:0]           iss_cause;
  logic                 iss_comp;
  assign emax = dprec ? fpu_pkg::EMAX_D : fpu_pkg::EMAX_S;
  assign qnan = dprec ? fpu_pkg::QNAN_D : {32'h0000_0000, fpu_pkg::QNAN_S};
  assign sx = ua.sign ^ ub.sign;
  assign rz = (rounding_mode_field == 2'h1);
  assign prod = ua.mant * ub.mant;
  assign pn = prod[105] ? prod : {prod[104:0], 1'b0};
  assign mr = rnd(dprec, rz, pn);
  assign me = ua.exp + ub.exp + (dprec ? fpu_pkg::BIAS_D : fpu_pkg::BIAS_S) + 13'(prod[105]) + 13'(mr[53]);

  always_comb
  begin
    iss_val = 64'h0;
    iss_wr = 1'b0;
    iss_cause = 6'h00;
    iss_comp = 1'b0;
    if (dec_op == fpu_pkg::OP_MUL)
    begin
      iss_wr = 1'b1;
      if (ua.cls == fpu_pkg::CL_SNAN || ub.cls == fpu_pkg::CL_SNAN)
      begin
        iss_cause[fpu_pkg::EX_V] = 1'b1;
        iss_val = qnan;
      end
      else if (ua.cls == fpu_pkg::CL_QNAN || ub.cls == fpu_pkg::CL_QNAN)
        iss_val = qnan;
      else if (ua.cls == fpu_pkg::CL_DENORM || ub.cls == fpu_pkg::CL_DENORM)
      begin
        iss_cause[fpu_pkg::EX_E] = 1'b1;
        iss_wr = 1'b0;
      end
      else if ((ua.cls == fpu_pkg::CL_ZERO && ub.cls == fpu_pkg::CL_INF) ||
               (ua.cls == fpu_pkg::CL_INF && ub.cls == fpu_pkg::CL_ZERO))
      begin
        iss_cause[fpu_pkg::EX_V] = 1'b1;
        iss_val = qnan;
      end
      else if (ua.cls == fpu_pkg::CL_ZERO || ub.cls == fpu_pkg::CL_ZERO)
        iss_val = pack(dprec, sx, 13'sh0000, 53'h0);
      else if (ua.cls == fpu_pkg::CL_INF || ub.cls == fpu_pkg::CL_INF)
        iss_val = pack(dprec, sx, emax, 53'h0);
      else if (me >= emax)
      begin
        iss_cause[fpu_pkg::EX_O] = 1'b1;
        iss_cause[fpu_pkg::EX_I] = 1'b1;
        iss_val = rz ? pack(dprec, sx, emax - 13'sh0001, {53{1'b1}}) : pack(dprec, sx, emax, 53'h0);
      end
      else if (me <= 13'sh0000)
      begin
        // no gradual underflow: tiny products flush to a signed zero
        iss_cause[fpu_pkg::EX_U] = 1'b1;
        iss_cause[fpu_pkg::EX_I] = 1'b1;
        iss_val = pack(dprec, sx, 13'sh0000, 53'h0);
      end
      else
      begin
        iss_cause[fpu_pkg::EX_I] = dprec ? |pn[52:0] : |pn[81:0];
        iss_val = pack(dprec, sx, me, mr[53] ? mr[53:1] : mr[52:0]);
      end
    end
    else if (dec_op == fpu_pkg::OP_NEG)
    begin
      iss_wr = 1'b1;
      iss_val = opn ^ (dprec ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000);
    end
    else if (dec_op == fpu_pkg::OP_SQRT)
    begin
      iss_wr = 1'b1;
      iss_val = qnan;
      if (ub.cls == fpu_pkg::CL_SNAN || (ub.sign && ub.cls != fpu_pkg::CL_ZERO && ub.cls != fpu_pkg::CL_QNAN))
        iss_cause[fpu_pkg::EX_V] = 1'b1;
      else if (ub.cls == fpu_pkg::CL_DENORM)
      begin
        iss_cause[fpu_pkg::EX_E] = 1'b1;
        iss_wr = 1'b0;
      end
      else if (ub.cls == fpu_pkg::CL_ZERO || ub.cls == fpu_pkg::CL_INF)
        iss_wr = 1'b0;
      else if (ub.cls == fpu_pkg::CL_NORM)
        iss_comp = 1'b1;
    end
  end

  // square root: four result bits per state, restoring, then rounded and squared back
  logic [111:0]         sq_x;
  logic [59:0]          sq_rem;
  logic [55:0]          sq_q;
  logic [53:0]          sq_y;
  logic signed [12:0]   sq_er;
  logic [111:0]         nx;
  logic [59:0]          nr;
  logic [55:0]          nq;
  logic [59:0]          tr;
  always_comb
  begin
    nx = sq_x;
    nr = sq_rem;
    nq = sq_q;
    tr = 60'h0;
    for (int k = 0; k < 4; k++)
    begin
      nr = {nr[57:0], nx[111:110]};
      tr = {2'h0, nq, 2'h1};
      if (nr >= tr)
      begin
        nr = nr - tr;
        nq = {nq[54:0], 1'b1};
      end
      else
        nq = {nq[54:0], 1'b0};
      nx = {nx[109:0], 2'h0};
    end
  end

  logic [53:0]          sq_t;
  logic [107:0]         sq_sq;
  logic [107:0]         sq_tgt;
  logic                 sq_dec;
  logic [53:0]          sq_f;
  assign sq_t = rnd(dbl, 1'b0, (dbl ? {sq_q, 50'h0} : {sq_q[27:0], 78'h0}) | {105'h0, |sq_rem});
  assign sq_sq = {54'h0, sq_t} * {54'h0, sq_t};
  assign sq_tgt = {2'h0, sq_y, 52'h0};
  assign sq_dec = (sq_sq > sq_tgt) && (rounding_mode_field == 2'h1);
  assign sq_f = sq_dec ? sq_t - (dbl ? 54'h1 : 54'h2000_0000) : sq_t;

  logic [63:0]          res_val;
  logic [5:0]           res_cause;
  logic                 res_trap;
  always_comb
  begin
    res_val = pend_val;
    res_cause = pend_cause;
    if (op == fpu_pkg::OP_SQRT && pend_comp)
    begin
      res_cause[fpu_pkg::EX_I] = (sq_sq != sq_tgt);
      res_val = pack(dbl, 1'b0, sq_er + (dbl ? fpu_pkg::BIAS_D : fpu_pkg::BIAS_S) + 13'(sq_f[53]),
                     sq_f[53] ? sq_f[53:1] : sq_f[52:0]);
    end
    res_trap = pend_force || |(res_cause & {1'b1, enable_f});
  end
  assign commit = (state == fpu_pkg::ST_RUN) && (cnt == 5'h00);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state <= fpu_pkg::ST_IDLE;
      o_busy <= 1'b0;
      op <= fpu_pkg::OP_NONE;
      cnt <= 5'h00;
      dbl <= 1'b0;
      bank <= 1'b0;
      dst <= 4'h0;
      pend_val <= 64'h0;
      pend_wr <= 1'b0;
      pend_cause <= 6'h00;
      pend_force <= 1'b0;
      pend_comp <= 1'b0;
    end
    else if (state == fpu_pkg::ST_IDLE)
    begin
      if (i_issue && dec_op != fpu_pkg::OP_NONE)
      begin
        state <= fpu_pkg::ST_RUN;
        o_busy <= 1'b1;
        op <= dec_op;
        dbl <= dprec;
        bank <= bank_select_bit;
        dst <= fld_n;
        pend_val <= iss_val;
        pend_wr <= iss_wr;
        pend_cause <= iss_cause;
        pend_comp <= iss_comp;
        pend_force <= (dec_op == fpu_pkg::OP_MUL && |enable_f[fpu_pkg::EX_O:fpu_pkg::EX_I]) ||
                      (dec_op == fpu_pkg::OP_SQRT && enable_f[fpu_pkg::EX_I]);
        case (dec_op)
          fpu_pkg::OP_MUL:  cnt <= (dprec ? fpu_pkg::LAT_DBL_MUL : fpu_pkg::LAT_SGL_MUL) - 5'h01;
          fpu_pkg::OP_SQRT: cnt <= (dprec ? fpu_pkg::LAT_DBL_SQRT : fpu_pkg::LAT_SGL_SQRT) - 5'h01;
          default:          cnt <= fpu_pkg::LAT_ONE - 5'h01;
        endcase
      end
    end
    else if (commit)
    begin
      state <= fpu_pkg::ST_IDLE;
      o_busy <= 1'b0;
    end
    else
      cnt <= cnt - 5'h01;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      sq_x <= 112'h0;
      sq_rem <= 60'h0;
      sq_q <= 56'h0;
      sq_y <= 54'h0;
      sq_er <= 13'sh0000;
      iter <= 4'h0;
    end
    else if (state == fpu_pkg::ST_IDLE && i_issue && dec_op == fpu_pkg::OP_SQRT)
    begin
      sq_y <= ub.exp[0] ? {ub.mant, 1'b0} : {1'b0, ub.mant};
      sq_x <= {(ub.exp[0] ? {ub.mant, 1'b0} : {1'b0, ub.mant}), 58'h0};
      sq_er <= ub.exp >>> 1;
      sq_rem <= 60'h0;
      sq_q <= 56'h0;
      iter <= iss_comp ? (dprec ? fpu_pkg::SQ_ITER_D : fpu_pkg::SQ_ITER_S) : 4'h0;
    end
    else if (iter != 4'h0)
    begin
      sq_x <= nx;
      sq_rem <= nr;
      sq_q <= nq;
      iter <= iter - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      float_status_control_reg <= fpu_pkg::FSCR_RESET;
    else
    begin
      if (i_bus.wr && i_bus.addr == fpu_pkg::OFF_FSCR)
        float_status_control_reg <= i_bus.wdata & fpu_pkg::FSCR_MASK;
      if (state == fpu_pkg::ST_IDLE && i_issue && (dec_op == fpu_pkg::OP_MUL || dec_op == fpu_pkg::OP_SQRT))
        float_status_control_reg[fpu_pkg::CAUSE_LSB +: 6] <= 6'h00;
      if (commit && (op == fpu_pkg::OP_MUL || op == fpu_pkg::OP_SQRT))
      begin
        // negate and the swaps never reach here, so their cause and flags stay put
        float_status_control_reg[fpu_pkg::CAUSE_LSB +: 6] <= res_cause;
        float_status_control_reg[fpu_pkg::FLAG_LSB +: 5] <=
          float_status_control_reg[fpu_pkg::FLAG_LSB +: 5] | res_cause[4:0];
      end
      if (commit && op == fpu_pkg::OP_BANK)
        float_status_control_reg[fpu_pkg::BANK_BIT] <= ~bank_select_bit;
      if (commit && op == fpu_pkg::OP_SIZE)
        float_status_control_reg[fpu_pkg::PAIR_BIT] <= ~transfer_pair_bit;
    end
  end

  // the unit wins over a software write to the same word in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_bus.wr && i_bus.addr[7])
      fpr[i_bus.addr[6:2]] <= i_bus.wdata;
    if (commit && pend_wr && !res_trap && op != fpu_pkg::OP_BANK && op != fpu_pkg::OP_SIZE)
    begin
      fpr[pidx(bank, dst, dbl, 1'b0)] <= dbl ? res_val[63:32] : res_val[31:0];
      if (dbl)
        fpr[pidx(bank, dst, 1'b1, 1'b1)] <= res_val[31:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_done <= 1'b0;
      o_trap <= 1'b0;
      o_undef <= 1'b0;
      o_transfer_pair <= 1'b0;
      o_bank_select <= 1'b0;
    end
    else
    begin
      o_done <= commit;
      o_trap <= commit && res_trap && (op == fpu_pkg::OP_MUL || op == fpu_pkg::OP_SQRT);
      o_undef <= state == fpu_pkg::ST_IDLE && i_issue && dec_op == fpu_pkg::OP_NONE;
      o_transfer_pair <= transfer_pair_bit;
      o_bank_select <= bank_select_bit;
    end
  end

  logic [IRQ_W_T-1:0]   irq_set;
  assign irq_set = {o_undef, o_trap, o_done};
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      irq_stat <= '0;
      irq_en <= '0;
      o_irq <= 1'b0;
    end
    else
    begin
      // a new event wins over a clear landing in the same cycle
      if (i_bus.wr && i_bus.addr == fpu_pkg::OFF_IRQ_CLR)
        irq_stat <= (irq_stat & ~i_bus.wdata[IRQ_W_T-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      if (i_bus.wr && i_bus.addr == fpu_pkg::OFF_IRQ_EN)
        irq_en <= i_bus.wdata[IRQ_W_T-1:0];
      o_irq <= |(irq_stat & irq_en);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_rdata <= 32'h0000_0000;
    else if (!i_bus.rd)
      o_rdata <= 32'h0000_0000;
    else if (i_bus.addr[7])
      o_rdata <= fpr[i_bus.addr[6:2]];
    else
      case (i_bus.addr)
        fpu_pkg::OFF_FSCR:     o_rdata <= float_status_control_reg;
        fpu_pkg::OFF_IRQ_STAT: o_rdata <= {29'h0000_0000, irq_stat};
        fpu_pkg::OFF_IRQ_EN:   o_rdata <= {29'h0000_0000, irq_en};
        default:               o_rdata <= 32'h0000_0000;
      endcase
  end
endmodule : fpu_exec

// file: fpu_exec_asserts.sv
`timescale 1ns/1ns
module fpu_exec_asserts (
  input wire logic              i_core_clk,
  input wire logic              i_srst,
  input wire logic              i_issue,
  input wire logic [15:0]       i_opcode,
  input wire fpu_pkg::bus_req_t i_bus,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic              o_trap,
  input wire logic              o_undef,
  input wire logic              o_irq,
  input wire logic              o_transfer_pair,
  input wire logic              o_bank_select
);
  logic       wide;
  logic       go;
  logic [7:0] lo;
  // only software writes the precision bit, so snooping the bus is enough
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      wide <= 1'b0;
    else if (i_bus.wr && i_bus.addr == fpu_pkg::OFF_FSCR)
      wide <= i_bus.wdata[fpu_pkg::PREC_BIT];
  end
  assign go = i_issue && !o_busy && i_opcode[15:12] == 4'hF;
  assign lo = i_opcode[7:0];
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  mul_single_a: assert property (go && !wide && lo[3:0] == 4'h2 |-> ##1 !o_done ##1 o_done && !o_busy)
    else $error("single multiply latency");
  mul_double_a: assert property (go && wide && lo[4:0] == 5'h02 && !i_opcode[8] |->
    ##6 o_busy && !o_done ##1 o_done) else $error("double multiply latency");
  neg_quiet_a: assert property (go && lo == 8'h4D && !i_opcode[8] |->
    ##1 !o_done ##1 o_done && !o_trap) else $error("negate latency or trap");
  sqrt_single_a: assert property (go && !wide && lo == 8'h6D |-> ##1 o_busy [*8] ##1 !o_done ##1 o_done)
    else $error("single root latency");
  sqrt_double_a: assert property (go && wide && lo == 8'h6D && !i_opcode[8] |->
    ##22 o_busy && !o_done ##1 o_done) else $error("double root latency");
  bank_flip_a: assert property (go && !wide && i_opcode == 16'hFBFD |->
    ##3 o_bank_select != $past(o_bank_select, 3)) else $error("bank select not flipped");
  size_flip_a: assert property (go && !wide && i_opcode == 16'hF3FD |->
    ##3 o_transfer_pair != $past(o_transfer_pair, 3)) else $error("transfer size not flipped");
  swap_undef_a: assert property (go && wide && lo == 8'hFD |->
    ##1 o_undef && !o_busy ##1 !o_done) else $error("swap in double mode accepted");
  trap_done_a: assert property (o_trap |-> o_done && !o_busy && $past(o_busy))
    else $error("trap outside completion");
  cover property (o_trap);
  cover property (o_undef);
  cover property (go && wide && lo == 8'h6D);
endmodule : fpu_exec_asserts

bind fpu_exec fpu_exec_asserts i_chk (.i_core_clk, .i_srst, .i_issue, .i_opcode, .i_bus, .o_rdata, .o_busy,
  .o_done, .o_trap, .o_undef, .o_irq, .o_transfer_pair, .o_bank_select);

// file: fpu_issuer.sv
`timescale 1ns/1ns
module fpu_issuer (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_go,
  input  wire logic [15:0] i_op,
  input  wire logic        i_slow,
  input  wire logic        i_busy,
  output logic             o_issue,
  output logic [15:0]      o_opcode
);
  logic        pend;
  logic        late;
  logic        fire;
  logic [15:0] hold;
  assign fire = pend && !i_busy && !o_issue && (late || !i_slow);
  // outside the issue cycle the word keeps toggling, so a stale sample shows up
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      pend     <= 1'b0;
      late     <= 1'b0;
      o_issue  <= 1'b0;
      o_opcode <= 16'h0000;
    end
    else
    begin
      late     <= pend;
      o_issue  <= fire;
      o_opcode <= fire ? hold : ~o_opcode;
      if (i_go)
        pend <= 1'b1;
      else if (fire)
        pend <= 1'b0;
      if (i_go)
        hold <= i_op;
    end
  end
endmodule : fpu_issuer

// file: tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] ST = fpu_pkg::OFF_FSCR;
  localparam logic [7:0] IE = fpu_pkg::OFF_IRQ_EN;
  logic              clk  = 1'b0;
  logic              srst = 1'b1;
  logic              go   = 1'b0;
  logic              slow = 1'b0;
  logic              samp = 1'b0;
  logic              rd_d = 1'b0;
  logic [15:0]       op   = 16'h0000;
  logic [15:0]       opc;
  logic [31:0]       rdata;
  logic [31:0]       r;
  logic [31:0]       seed = 32'h6430_404a;
  logic              issue, busy, done, trap, undef, irq, pair, bank;
  fpu_pkg::bus_req_t bus  = '0;
  logic [31:0]       exp_q[$];
  int                fail_count = 0;
  int                samples_checked = 0;
  logic [31:0]       ens[3] = '{32'h0000_0080, 32'h0000_0100, 32'h0000_0200};

  always #50 clk = ~clk;

  fpu_issuer i_cpu (.i_core_clk(clk), .i_srst(srst), .i_go(go), .i_op(op), .i_slow(slow), .i_busy(busy),
    .o_issue(issue), .o_opcode(opc));
  fpu_exec i_dut (.i_core_clk(clk), .i_srst(srst), .i_issue(issue), .i_opcode(opc), .i_bus(bus), .o_rdata(rdata),
    .o_busy(busy), .o_done(done), .o_trap(trap), .o_undef(undef), .o_irq(irq), .o_transfer_pair(pair),
    .o_bank_select(bank));

  function automatic logic [7:0] ra(input int i);
    return fpu_pkg::OFF_FPR_BASE + 8'(4 * i);
  endfunction : ra

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] got);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
    samples_checked++;
    if (e !== got)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, got);
      fail_count++;
    end
  endtask : check

  always @(posedge clk)
  begin
    if (rd_d)
      check("rdata", rdata);
    if (done | undef)
      check("outcome", {30'h0, undef, trap});
    if (samp)
      check("levels", {29'h0, irq, bank, pair});
    rd_d <= bus.rd;
  end

  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(a, rnd(), 1'b0);
  endtask : rd

  task automatic run(input logic [15:0] o, input logic [1:0] c);
    int k = 0;
    exp_q.push_back({30'h0, c});
    op   <= o;
    go   <= 1'b1;
    slow <= seed[0];
    @(posedge clk);
    go <= 1'b0;
    while (!(done | undef) && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 40)
      fail_count++;
    @(posedge clk);
  endtask : run

  task automatic t(input int n, m, input logic [31:0] a, b, input logic [15:0] o, input logic [1:0] c,
                   input logic [31:0] e);
    acc(ra(n), a, 1'b1);
    acc(ra(m), b, 1'b1);
    run(o, c);
    rd(ra(n), e);
  endtask : t

  task automatic lv(input logic [2:0] e);
    @(posedge clk);
    exp_q.push_back({29'h0, e});
    samp <= 1'b1;
    @(posedge clk);
    samp <= 1'b0;
    @(posedge clk);
  endtask : lv

  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(ST, 32'h0000_0000);
    t(1, 2, 32'h4000_0000, 32'h4040_0000, 16'hF122, 2'h0, 32'h40C0_0000);
    t(3, 4, 32'h7F80_0001, 32'h4000_0000, 16'hF342, 2'h0, 32'h7FC0_0000);
    rd(ST, 32'h0001_0040);
    repeat (3)
    begin
      r = rnd();
      t(int'(r[3:0]), int'(r[3:0]), r, r, {4'hF, r[3:0], 8'h4D}, 2'h0, r ^ 32'h8000_0000);
    end
    rd(ST, 32'h0001_0040);
    t(3, 4, 32'h4000_0000, 32'h7FC1_2345, 16'hF342, 2'h0, 32'h7FC0_0000);
    rd(ST, 32'h0000_0040);
    t(5, 6, 32'h0000_0001, 32'h4000_0000, 16'hF562, 2'h1, 32'h0000_0001);
    acc(ST, 32'h0004_0000, 1'b1);
    t(5, 6, 32'h0000_0001, 32'h4000_0000, 16'hF562, 2'h0, 32'h0000_0000);
    foreach (ens[i])
    begin
      acc(ST, ens[i], 1'b1);
      t(1, 2, 32'h4000_0000, 32'h4040_0000, 16'hF122, 2'h1, 32'h4000_0000);
    end
    acc(ST, 32'h0000_0001, 1'b1);
    t(7, 7, 32'h40A0_0000, 32'h40A0_0000, 16'hF76D, 2'h0, 32'h400F_1BBC);
    rd(ST, 32'h0000_1005);
    acc(ST, 32'h0000_0000, 1'b1);
    t(8, 8, 32'hBF80_0000, 32'hBF80_0000, 16'hF86D, 2'h0, 32'h7FC0_0000);
    t(8, 8, 32'h4080_0000, 32'h4080_0000, 16'hF86D, 2'h0, 32'h4000_0000);
    acc(ST, 32'h0000_0080, 1'b1);
    t(8, 8, 32'h4080_0000, 32'h4080_0000, 16'hF86D, 2'h1, 32'h4080_0000);
    acc(ST, 32'h0008_0000, 1'b1);
    acc(ra(3), 32'h0000_0000, 1'b1);
    acc(ra(5), 32'h0000_0000, 1'b1);
    t(2, 4, 32'h4000_0000, 32'h4008_0000, 16'hF242, 2'h0, 32'h4018_0000);
    run(16'hF24D, 2'h0);
    rd(ra(2), 32'hC018_0000);
    rd(ra(3), 32'h0000_0000);
    t(2, 2, 32'h4010_0000, 32'h4010_0000, 16'hF26D, 2'h0, 32'h4000_0000);
    run(16'hFBFD, 2'h2);
    run(16'hF3FD, 2'h2);
    acc(ST, 32'h0000_0000, 1'b1);
    run(16'hFBFD, 2'h0);
    lv(3'h2);
    t(16, 17, 32'h4000_0000, 32'h4040_0000, 16'hF012, 2'h0, 32'h40C0_0000);
    run(16'hFBFD, 2'h0);
    run(16'hF3FD, 2'h0);
    lv(3'h1);
    rd(ST, 32'h0010_0000);
    acc(IE, 32'h0000_0007, 1'b1);
    lv(3'h5);
    acc(fpu_pkg::OFF_IRQ_CLR, 32'h0000_0007, 1'b1);
    rd(fpu_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    acc(IE, 32'h0000_0002, 1'b1);
    run(16'hF04D, 2'h0);
    lv(3'h1);
    rd(fpu_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    rd(8'h40, 32'h0000_0000);
    rd(fpu_pkg::OFF_IRQ_CLR, 32'h0000_0000);
    close_out();
  end
endmodule : tb
